// >>> ocu_defs.vh
// Constants for the timer compare-output control block.
// Included by every design file; definitions only.
`ifndef OCU_DEFS_VH
`define OCU_DEFS_VH
// Register word offsets (byte addresses)
`define OFS_T1_MODE_CTRL   4'h0
`define OFS_T1_MODE_HIGH   4'h4
`define OFS_T3_MODE_CTRL   4'h8
`define OFS_T3_MODE_HIGH   4'hC
// Control register A field positions
`define CHA_MSB            7
`define CHA_LSB            6
`define CHB_MSB            5
`define CHB_LSB            4
`define CHC_MSB            3
`define CHC_LSB            2
`define WMODE_LOW_MSB      1
`define WMODE_LOW_LSB      0
// Reset values
`define CTRL_RESET         8'h00
`define HIGH_RESET         2'h0
// Output mode codes
`define OUT_OFF            2'h0
`define OUT_TOGGLE         2'h1
`define OUT_CLEAR          2'h2
`define OUT_SET            2'h3
// Waveform modes of note
`define WMODE_FAST_TOGGLE  4'hF
`define WMODE_DUAL_TOGGLE_0 4'h9
`define WMODE_DUAL_TOGGLE_1 4'hB
`endif

// >>> mode_class.v
// Waveform mode classifier: splits the 4-bit mode into its class.
// Assumes the mode is a stable register value.
`timescale 1ns/1ns
`include "ocu_defs.vh"
module mode_class (
  input  wire [3:0] waveform_mode_i,
  output reg        is_fast_o,
  output reg        is_dual_o
);
  always @* begin
    is_fast_o = 1'b0;
    is_dual_o = 1'b0;
    case (waveform_mode_i)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
        is_fast_o = 1'b1;
      end
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: begin
        is_dual_o = 1'b1;
      end
      default: begin
        is_fast_o = 1'b0;
      end
    endcase
  end
endmodule // mode_class

// >>> wave_channel.v
// One compare-output channel: latch, pin takeover and mode decode.
// Assumes timer events are one-cycle pulses qualified by the timer enable.
`timescale 1ns/1ns
`include "ocu_defs.vh"
module wave_channel (
  // Clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // Configuration
  input  wire [1:0] out_mode_i,
  input  wire [3:0] waveform_mode_i,
  input  wire       is_fast_i,
  input  wire       is_dual_i,
  input  wire       is_chan_a_i,
  // Timer events
  input  wire       match_i,
  input  wire       bottom_i,
  input  wire       match_at_top_i,
  input  wire       count_down_i,
  // Outputs
  output reg        wave_o,
  output reg        override_o
);
  reg next_wave;
  reg toggle_ok;
  always @* begin
    toggle_ok = 1'b1;
    if (is_fast_i) begin
      toggle_ok = is_chan_a_i && (waveform_mode_i == `WMODE_FAST_TOGGLE);
    end else if (is_dual_i) begin
      toggle_ok = is_chan_a_i && ((waveform_mode_i == `WMODE_DUAL_TOGGLE_0) ||
                                  (waveform_mode_i == `WMODE_DUAL_TOGGLE_1));
    end
  end
  always @* begin
    next_wave = wave_o;
    case (out_mode_i)
      `OUT_TOGGLE: begin
        if (match_i && toggle_ok) next_wave = ~wave_o;
      end
      `OUT_CLEAR, `OUT_SET: begin
        if (is_fast_i) begin
          if (bottom_i) next_wave = (out_mode_i == `OUT_CLEAR);
          else if (match_i && !match_at_top_i) next_wave = out_mode_i[0];
        end else if (is_dual_i) begin
          // Up clears, down sets for code 10; so top match holds high
          if (match_i) next_wave = out_mode_i[0] ^ count_down_i;
        end else if (match_i) begin
          next_wave = out_mode_i[0];
        end
      end
      default: begin
        next_wave = wave_o;
      end
    endcase
  end
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      wave_o     <= 1'b0;
      override_o <= 1'b0;
    end else begin
      wave_o     <= next_wave;
      // Pin driver still needs the port direction bit
      override_o <= |out_mode_i && (toggle_ok || out_mode_i[1]);
    end
  end
endmodule // wave_channel

// >>> timer16_compare_output_control.v
// Compare-output control for two 16-bit timer instances, Avalon-MM slave.
// Assumes counter events arrive synchronous to MCLK_I as one-cycle pulses.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ocu_defs.vh"
module timer16_compare_output_control (
  // Clock and reset
  input  wire       MCLK_I,
  input  wire       NRST_I,
  // Avalon-MM slave
  input  wire [3:0] ADDRESS_I,
  input  wire       READ_I,
  input  wire       WRITE_I,
  input  wire [31:0] WRITEDATA_I,
  input  wire [3:0] BYTEENABLE_I,
  output reg  [31:0] READDATA_O,
  output reg        WAITREQUEST_O,
  // Timer events, index 0 timer1, 1 timer3
  input  wire [1:0] BOTTOM_I,
  input  wire [1:0] COUNT_DOWN_I,
  input  wire [5:0] MATCH_I,
  input  wire [5:0] MATCH_AT_TOP_I,
  // Waveform outputs, bits {t3c,t3b,t3a,t1c,t1b,t1a}
  output reg  [5:0] WAVE_OUT_O,
  output reg  [5:0] PIN_OVERRIDE_O
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;
  reg [1:0] state;
  reg [7:0] ctrl [0:1];
  reg [1:0] mode_high [0:1];
  wire [5:0] wave;
  wire [5:0] ovr;
  wire       req = READ_I | WRITE_I;
  // One wait cycle: answer registered, keeps read data from a flop
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      state         <= ST_IDLE;
      WAITREQUEST_O <= 1'b1;
      READDATA_O    <= 32'h0;
      ctrl[0]       <= `CTRL_RESET;
      ctrl[1]       <= `CTRL_RESET;
      mode_high[0]  <= `HIGH_RESET;
      mode_high[1]  <= `HIGH_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req) begin
            state         <= ST_DONE;
            WAITREQUEST_O <= 1'b0;
            READDATA_O    <= 32'h0;
            case (ADDRESS_I)
              `OFS_T1_MODE_CTRL: READDATA_O[7:0] <= ctrl[0];
              `OFS_T3_MODE_CTRL: READDATA_O[7:0] <= ctrl[1];
              `OFS_T1_MODE_HIGH: READDATA_O[1:0] <= mode_high[0];
              `OFS_T3_MODE_HIGH: READDATA_O[1:0] <= mode_high[1];
              default: READDATA_O <= 32'h0;
            endcase
            if (WRITE_I && BYTEENABLE_I[0]) begin
              case (ADDRESS_I)
                `OFS_T1_MODE_CTRL: ctrl[0] <= WRITEDATA_I[7:0];
                `OFS_T3_MODE_CTRL: ctrl[1] <= WRITEDATA_I[7:0];
                `OFS_T1_MODE_HIGH: mode_high[0] <= WRITEDATA_I[1:0];
                `OFS_T3_MODE_HIGH: mode_high[1] <= WRITEDATA_I[1:0];
                default: state <= ST_DONE;
              endcase
            end
          end
        end
        ST_DONE: begin
          state         <= ST_IDLE;
          WAITREQUEST_O <= 1'b1;
        end
        default: begin
          state         <= ST_IDLE;
          WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_timer
      wire [3:0] waveform_mode = {mode_high[t], ctrl[t][`WMODE_LOW_MSB:`WMODE_LOW_LSB]};
      wire       is_fast;
      wire       is_dual;
      wire [5:0] field = {ctrl[t][`CHC_MSB:`CHC_LSB], ctrl[t][`CHB_MSB:`CHB_LSB],
                          ctrl[t][`CHA_MSB:`CHA_LSB]};
      mode_class u_class (
        .waveform_mode_i (waveform_mode),
        .is_fast_o       (is_fast),
        .is_dual_o       (is_dual)
      );
      genvar c;
      for (c = 0; c < 3; c = c + 1) begin : g_chan
        wave_channel u_chan (
          .clk_i           (MCLK_I),
          .nrst_i          (NRST_I),
          .out_mode_i      (field[2*c+1:2*c]),
          .waveform_mode_i (waveform_mode),
          .is_fast_i       (is_fast),
          .is_dual_i       (is_dual),
          .is_chan_a_i     (c == 0),
          .match_i         (MATCH_I[3*t+c]),
          .bottom_i        (BOTTOM_I[t]),
          .match_at_top_i  (MATCH_AT_TOP_I[3*t+c]),
          .count_down_i    (COUNT_DOWN_I[t]),
          .wave_o          (wave[3*t+c]),
          .override_o      (ovr[3*t+c])
        );
      end
    end
  endgenerate
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      WAVE_OUT_O     <= 6'h00;
      PIN_OVERRIDE_O <= 6'h00;
    end else begin
      WAVE_OUT_O     <= wave;
      PIN_OVERRIDE_O <= ovr;
    end
  end
endmodule // timer16_compare_output_control

// >>> timer16_compare_output_control_props.sv
// Port checker for the compare-output block.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/1ns
module timer16_compare_output_control_props (
  input logic        MCLK_I, NRST_I, READ_I, WRITE_I, WAITREQUEST_O,
  input logic [3:0]  ADDRESS_I,
  input logic [31:0] READDATA_O,
  input logic [1:0]  BOTTOM_I,
  input logic [5:0]  MATCH_I, WAVE_OUT_O, PIN_OVERRIDE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  wire req = READ_I | WRITE_I;
  sequence idle_req;
    req && WAITREQUEST_O && $past(WAITREQUEST_O);
  endsequence
  sequence read_done;
    !WAITREQUEST_O && $past(READ_I);
  endsequence
  bus_answer_a: assert property (idle_req |=> !WAITREQUEST_O)
    else $error("bus request not answered in one cycle");
  answer_once_a: assert property (!WAITREQUEST_O |=> WAITREQUEST_O)
    else $error("answer stood longer than one cycle");
  idle_wait_a: assert property (!req |=> WAITREQUEST_O)
    else $error("answer without request");
  read_width_a: assert property (read_done |-> READDATA_O[31:8] == 24'h0)
    else $error("read data above the register width");
  unmapped_zero_a: assert property (read_done and $past(ADDRESS_I[1:0]) != 2'h0
    |-> READDATA_O == 32'h0) else $error("unmapped read not zero");
  for (genvar k = 0; k < 6; k++) begin : g_ch
    wave_cause_a: assert property ($changed(WAVE_OUT_O[k])
      |-> $past(MATCH_I[k] | BOTTOM_I[k / 3], 2)) else $error("output moved without event");
    wave_held_a: assert property ($changed(WAVE_OUT_O[k]) |-> $past(PIN_OVERRIDE_O[k]))
      else $error("disconnected channel moved");
    override_cause_a: assert property ($changed(PIN_OVERRIDE_O[k])
      |-> $past(WRITE_I, 2) || $past(WRITE_I, 3) || $past(WRITE_I, 4))
      else $error("pin takeover changed without write");
  end
endmodule // timer16_compare_output_control_props

// >>> test_timer16_compare_output_control.sv
// Testbench for the compare-output block: registers, events and pins.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ns
module test_timer16_compare_output_control;
  logic        mclk, nrst, rd, wr;
  logic [3:0]  adr;
  logic [31:0] wdat, got;
  logic [1:0]  bot, dn;
  logic [5:0]  mat, top;
  wire  [31:0] rdat;
  wire         wrq;
  wire  [5:0]  wave, ovr;
  int          err_count, checked;
  timer16_compare_output_control dut (.MCLK_I(mclk), .NRST_I(nrst), .ADDRESS_I(adr),
    .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdat), .BYTEENABLE_I(4'hF),
    .READDATA_O(rdat), .WAITREQUEST_O(wrq), .BOTTOM_I(bot), .COUNT_DOWN_I(dn),
    .MATCH_I(mat), .MATCH_AT_TOP_I(top), .WAVE_OUT_O(wave), .PIN_OVERRIDE_O(ovr));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until waitrequest low is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= !w; wr <= w; adr <= a; wdat <= d;
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (wrq === 1'b0) break;
    end
    got = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readback", got, e);
  endtask
  task automatic ochk(input logic [5:0] e);
    repeat (4) @(posedge mclk);
    #1 chk("override", ovr, e);
  endtask
  // One event pulse; output lands two edges later
  task automatic ev(input logic [5:0] m, e, input logic [1:0] b, d, input logic [5:0] t);
    @(posedge mclk);
    mat <= m; bot <= b; top <= t; dn <= d;
    @(posedge mclk);
    mat <= 6'h0; bot <= 2'h0;
    @(posedge mclk);
    #1 chk("wave", wave, e);
  endtask
  task automatic t_regs;
    chk("reset pins", {ovr, wave}, 32'h0);
    rchk(4'h0, 32'h0);
    rchk(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'hE7);
    rchk(4'h0, 32'hE7);
    bus(1'b1, 4'h4, 32'h3);
    rchk(4'h4, 32'h3);
    rchk(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
  endtask
  task automatic t_nonpwm;
    bus(1'b1, 4'h0, 32'h6C);
    ochk(6'h07);
    ev(6'h3F, 6'h05, 2'h0, 2'h0, 6'h0);
    ev(6'h07, 6'h04, 2'h0, 2'h0, 6'h0);
  endtask
  task automatic t_fast;
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b1, 4'h0, 32'hB5);
    ochk(6'h03);
    ev(6'h00, 6'h05, 2'h1, 2'h0, 6'h0);
    ev(6'h03, 6'h06, 2'h0, 2'h0, 6'h0);
    ev(6'h01, 6'h06, 2'h0, 2'h0, 6'h01);
    ev(6'h00, 6'h05, 2'h1, 2'h0, 6'h0);
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b1, 4'h0, 32'h43);
    ochk(6'h01);
    ev(6'h01, 6'h04, 2'h0, 2'h0, 6'h0);
  endtask
  task automatic t_dual;
    bus(1'b1, 4'hC, 32'h2);
    bus(1'b1, 4'h8, 32'hB7);
    ochk(6'h19);
    ev(6'h18, 6'h14, 2'h0, 2'h0, 6'h0);
    ev(6'h18, 6'h0C, 2'h0, 2'h2, 6'h0);
    bus(1'b1, 4'h8, 32'h41);
    ev(6'h08, 6'h04, 2'h0, 2'h2, 6'h0);
    bus(1'b1, 4'h8, 32'h42);
    ochk(6'h01);
  endtask
  task tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {nrst, rd, wr, adr, wdat, bot, dn, mat, top} = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs;
    t_nonpwm;
    t_fast;
    t_dual;
    tally_and_finish;
  end
  // Whole run is about 110 cycles
  initial begin
    #40000;
    err_count++;
    tally_and_finish;
  end
endmodule // test_timer16_compare_output_control
bind timer16_compare_output_control timer16_compare_output_control_props u_props (
  .MCLK_I(MCLK_I), .NRST_I(NRST_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
  .WAITREQUEST_O(WAITREQUEST_O), .ADDRESS_I(ADDRESS_I), .READDATA_O(READDATA_O),
  .BOTTOM_I(BOTTOM_I), .MATCH_I(MATCH_I), .WAVE_OUT_O(WAVE_OUT_O),
  .PIN_OVERRIDE_O(PIN_OVERRIDE_O));
